// ===== sfa_enc_model.sv
// partner model: absolute encoder status flags and its reset handshake
// assumes requests from the bench on sys_clk
`timescale 1ns/1ps
module sfa_enc_model (
   input wire logic sys_clk,
   input wire logic [7:0] flagReq,
   input wire logic resetReq,
   output logic [7:0] encFlags,
   output logic encResetDone
);
   // ****************************************
   // encoder status, one cycle behind request
   // ****************************************
   always_ff @(posedge sys_clk) begin
      encResetDone <= resetReq;
      if (resetReq) begin
         encFlags <= 8'h00;
      end else begin
         encFlags <= flagReq;
      end
   end
endmodule

// ===== sfa_fault_unit.sv
// servo fault detector, code latch and alarm status over APB
// assumes encoder/EEPROM/ADC flags on sys_clk, pins asynchronous
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module sfa_fault_unit #(
   parameter int AIN_W = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pos_limit_in,
   input wire logic neg_limit_in,
   input wire logic alarm_clear_in,
   input wire logic eepDone,
   input wire logic eepParamBad,
   input wire logic eepCheckBad,
   input wire logic [1:0] eepSub,
   input wire logic [AIN_W-1:0] ain1Val,
   input wire logic [AIN_W-1:0] ain2Val,
   input wire logic [AIN_W-1:0] ain3Val,
   input wire logic encBackupLow,
   input wire logic encMultiOver,
   input wire logic encBattOverspeed,
   input wire logic encInitFail,
   input wire logic encSingleErr,
   input wire logic encMultiErr,
   input wire logic encStartOverspeed,
   input wire logic encIndexMissing,
   input wire logic encResetDone,
   output logic faultActive,
   output logic [7:0] faultMain,
   output logic [3:0] faultSub,
   output logic irq
);
   initial begin
      if (AIN_W < 1 || AIN_W > 16) $error("AIN_W must be 1 to 16");
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   sfa_sync_if #(.W(3)) pinIf ();
   assign pinIf.raw = {alarm_clear_in, neg_limit_in, pos_limit_in};

   sfa_sync3 #(.W(3)) pinSync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .port(pinIf.sync)
   );

   logic posLim;
   logic negLim;
   logic clrLvl;
   logic clrPrev_q;
   logic clrRise;
   assign posLim = pinIf.clean[0];
   assign negLim = pinIf.clean[1];
   assign clrLvl = pinIf.clean[2];
   assign clrRise = clrLvl & ~clrPrev_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) clrPrev_q <= 1'b0;
      else clrPrev_q <= clrLvl;
   end

   // ****************************************
   // registers
   // ****************************************
   logic [1:0] otCfg_q;
   logic [1:0] absCfg_q;
   logic [15:0] ain1Limit_q;
   logic [15:0] ain2Limit_q;
   logic [15:0] ain3Limit_q;
   logic [1:0] irqStat_q;
   logic [1:0] irqStat_d;
   logic [1:0] irqMask_q;
   logic active_q;
   logic [7:0] main_q;
   logic [3:0] sub_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   logic setup;
   logic wrDone;
   logic mapped;
   assign setup = psel & penable & ~pready_q;
   assign wrDone = psel & penable & pready_q & pwrite;
   assign mapped = (paddr == sfa_pkg::REG_CTRL) || (paddr == sfa_pkg::REG_AIN1) ||
                   (paddr == sfa_pkg::REG_AIN2) || (paddr == sfa_pkg::REG_AIN3) ||
                   (paddr == sfa_pkg::REG_STATUS) || (paddr == sfa_pkg::REG_IRQ_STAT) ||
                   (paddr == sfa_pkg::REG_IRQ_MASK);

   // ****************************************
   // apb answer, one wait state
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else if (setup) begin
         pready_q <= 1'b1;
         pslverr_q <= ~mapped;
         prdata_q <= 32'h0;
         if (!pwrite) begin
            case (paddr)
               sfa_pkg::REG_CTRL: begin
                  prdata_q[sfa_pkg::CTRL_OT_LSB +: 2] <= otCfg_q;
                  prdata_q[sfa_pkg::CTRL_ABS_LSB +: 2] <= absCfg_q;
               end
               sfa_pkg::REG_AIN1: prdata_q[15:0] <= ain1Limit_q;
               sfa_pkg::REG_AIN2: prdata_q[15:0] <= ain2Limit_q;
               sfa_pkg::REG_AIN3: prdata_q[15:0] <= ain3Limit_q;
               sfa_pkg::REG_STATUS: begin
                  prdata_q[sfa_pkg::STAT_SUB_LSB +: 4] <= sub_q;
                  prdata_q[sfa_pkg::STAT_MAIN_LSB +: 8] <= main_q;
                  prdata_q[sfa_pkg::STAT_ACT_BIT] <= active_q;
               end
               sfa_pkg::REG_IRQ_STAT: prdata_q[1:0] <= irqStat_q;
               sfa_pkg::REG_IRQ_MASK: prdata_q[1:0] <= irqMask_q;
               default: prdata_q <= 32'h0;
            endcase
         end
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         otCfg_q <= sfa_pkg::OT_RST;
         absCfg_q <= sfa_pkg::ABS_RST;
         ain1Limit_q <= sfa_pkg::AIN_LIMIT_RST;
         ain2Limit_q <= sfa_pkg::AIN_LIMIT_RST;
         ain3Limit_q <= sfa_pkg::AIN_LIMIT_RST;
         irqMask_q <= sfa_pkg::IRQ_MASK_RST;
      end else if (wrDone) begin
         case (paddr)
            sfa_pkg::REG_CTRL: begin
               otCfg_q <= pwdata[sfa_pkg::CTRL_OT_LSB +: 2];
               absCfg_q <= pwdata[sfa_pkg::CTRL_ABS_LSB +: 2];
            end
            sfa_pkg::REG_AIN1: ain1Limit_q <= pwdata[15:0];
            sfa_pkg::REG_AIN2: ain2Limit_q <= pwdata[15:0];
            sfa_pkg::REG_AIN3: ain3Limit_q <= pwdata[15:0];
            sfa_pkg::REG_IRQ_MASK: irqMask_q <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // fault causes
   // ****************************************
   logic [15:0] ain1Ext;
   logic [15:0] ain2Ext;
   logic [15:0] ain3Ext;
   logic [2:0] ainOver;
   logic otHit;
   assign ain1Ext = 16'(ain1Val);
   assign ain2Ext = 16'(ain2Val);
   assign ain3Ext = 16'(ain3Val);
   // zero limit switches the check off
   assign ainOver[0] = (ain1Limit_q != 16'h0) && (ain1Ext > ain1Limit_q);
   assign ainOver[1] = (ain2Limit_q != 16'h0) && (ain2Ext > ain2Limit_q);
   assign ainOver[2] = (ain3Limit_q != 16'h0) && (ain3Ext > ain3Limit_q);
   assign otHit = ((otCfg_q == sfa_pkg::OT_BOTH) && posLim && negLim) ||
                  ((otCfg_q == sfa_pkg::OT_EITHER) && (posLim || negLim));

   logic detHit;
   logic [7:0] detMain;
   logic [3:0] detSub;

   // lowest code wins when causes coincide
   always_comb begin
      detHit = 1'b1;
      detSub = sfa_pkg::SUB_0;
      detMain = 8'h0;
      if (eepDone && eepParamBad) begin
         detMain = sfa_pkg::FC_EEP_PARAM;
         detSub = {2'h0, eepSub};
      end else if (eepDone && eepCheckBad) begin
         detMain = sfa_pkg::FC_EEP_CHECK;
         detSub = {2'h0, eepSub};
      end else if (otHit) begin
         detMain = sfa_pkg::FC_OVERTRAVEL;
      end else if (|ainOver) begin
         detMain = sfa_pkg::FC_AIN_OVER;
         detSub = ainOver[0] ? sfa_pkg::SUB_0 : (ainOver[1] ? sfa_pkg::SUB_1 : sfa_pkg::SUB_2);
      end else if (encBackupLow) begin
         detMain = sfa_pkg::FC_ABS_DOWN;
      end else if (encMultiOver && absCfg_q != sfa_pkg::ABS_IGNORE_OVF) begin
         detMain = sfa_pkg::FC_ABS_OVF;
      end else if (encBattOverspeed) begin
         detMain = sfa_pkg::FC_ABS_OVSPD;
      end else if (encInitFail) begin
         detMain = sfa_pkg::FC_ENC_INIT;
      end else if (encSingleErr) begin
         detMain = sfa_pkg::FC_SINGLE_CNT;
      end else if (encMultiErr) begin
         detMain = sfa_pkg::FC_MULTI_CNT;
      end else if (encStartOverspeed) begin
         detMain = sfa_pkg::FC_START_SPD;
      end else if (encIndexMissing) begin
         detMain = sfa_pkg::FC_INDEX_MISS;
      end else begin
         detHit = 1'b0;
      end
   end

   // ****************************************
   // fault latch and clear
   // ****************************************
   logic clearOk;
   logic raiseEv;
   always_comb begin
      case (main_q)
         sfa_pkg::FC_AIN_OVER: clearOk = clrRise && !(|ainOver);
         sfa_pkg::FC_ABS_DOWN, sfa_pkg::FC_ABS_OVSPD: clearOk = encResetDone;
         default: clearOk = 1'b0;
      endcase
   end
   assign raiseEv = ~active_q & detHit;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         active_q <= 1'b0;
         main_q <= 8'h0;
         sub_q <= 4'h0;
      end else if (raiseEv) begin
         active_q <= 1'b1;
         main_q <= detMain;
         sub_q <= detSub;
      end else if (active_q && clearOk) begin
         active_q <= 1'b0;
         main_q <= 8'h0;
         sub_q <= 4'h0;
      end
   end

   // ****************************************
   // interrupt status, set wins over clear
   // ****************************************
   logic [1:0] irqEv;
   logic [1:0] w1c;
   assign irqEv = {active_q & clearOk, raiseEv};
   assign w1c = (wrDone && paddr == sfa_pkg::REG_IRQ_STAT) ? pwdata[1:0] : 2'h0;
   assign irqStat_d = (irqStat_q & ~w1c) | irqEv;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) irqStat_q <= 2'h0;
      else irqStat_q <= irqStat_d;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) irq_q <= 1'b0;
      else irq_q <= |(irqStat_d & irqMask_q);
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign faultActive = active_q;
   assign faultMain = main_q;
   assign faultSub = sub_q;
   assign irq = irq_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   AST_EEP_PARAM: assert property (
      !faultActive && eepDone && eepParamBad |=> faultActive && faultMain == 8'd36 && faultSub == {2'h0, $past(eepSub)})
      else $error("parameter corruption not latched as 36");
   AST_EEP_CHECK: assert property (
      !faultActive && eepDone && eepCheckBad && !eepParamBad |=> faultMain == 8'd37)
      else $error("check code corruption not latched as 37");
   AST_OT_BOTH: assert property (
      !faultActive && otCfg_q == 2'h0 && posLim && negLim && !eepDone |=> faultMain == 8'd38 && faultSub == 4'h0)
      else $error("both limits did not raise 38");
   AST_OT_EITHER: assert property (
      !faultActive && otCfg_q == 2'h2 && (posLim ^ negLim) && !eepDone |=> faultMain == 8'd38)
      else $error("single limit did not raise 38");
   AST_AIN2: assert property (
      !faultActive && ainOver == 3'b010 && !eepDone && !otHit |=> faultMain == 8'd39 && faultSub == 4'h1)
      else $error("analog input 2 excess not sub 1");
   AST_AIN_OFF: assert property (
      faultActive && !$past(faultActive) && faultMain == 8'd39 && faultSub == 4'h0 |-> $past(ain1Limit_q) != 16'h0)
      else $error("zero threshold still raised 39");
   AST_ABS_HOLD: assert property (
      faultActive && (faultMain == 8'd40 || faultMain == 8'd42) && !encResetDone |=> faultActive && $stable(faultMain))
      else $error("40 or 42 released without encoder reset");
   AST_OVF_IGNORE: assert property (
      !faultActive && absCfg_q == 2'h2 |=> !(faultActive && faultMain == 8'd41))
      else $error("41 raised while overflow ignored");
   AST_NO_CLEAR: assert property (
      faultActive && faultMain != 8'd39 && faultMain != 8'd40 && faultMain != 8'd42 |=> faultActive && $stable(faultMain))
      else $error("power-cycle fault cleared");
   AST_CLR39: assert property (
      faultActive && faultMain == 8'd39 && clrRise && ainOver == 3'b000 |=> !faultActive && irqStat_q[1])
      else $error("39 not cleared by alarm clear");
   AST_FIRST_HELD: assert property (
      faultActive && !clearOk |=> $stable(faultMain) && $stable(faultSub))
      else $error("latched code overwritten");

   COV_RAISE: cover property (!faultActive ##1 faultActive);
   COV_CLR39: cover property (faultActive && faultMain == 8'd39 ##1 !faultActive);
   COV_ENC_RESET: cover property (faultActive && faultMain == 8'd40 && encResetDone ##1 !faultActive);
   COV_IRQ: cover property (!irq ##1 irq);
endmodule

// ===== sfa_pkg.sv
// constants for the servo fault alarm unit
// assumes one 200 MHz clock and an APB master
package sfa_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_AIN1 = 8'h04;
   localparam logic [7:0] REG_AIN2 = 8'h08;
   localparam logic [7:0] REG_AIN3 = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_STAT = 8'h14;
   localparam logic [7:0] REG_IRQ_MASK = 8'h18;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int CTRL_OT_LSB = 0;
   localparam int CTRL_ABS_LSB = 4;
   localparam int STAT_SUB_LSB = 0;
   localparam int STAT_MAIN_LSB = 8;
   localparam int STAT_ACT_BIT = 16;
   localparam int IRQ_RAISE_BIT = 0;
   localparam int IRQ_CLEAR_BIT = 1;
   localparam logic [1:0] OT_RST = 2'h1;
   localparam logic [1:0] ABS_RST = 2'h0;
   localparam logic [15:0] AIN_LIMIT_RST = 16'h0000;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   // ****************************************
   // settings and codes
   // ****************************************
   localparam logic [1:0] OT_BOTH = 2'h0;
   localparam logic [1:0] OT_EITHER = 2'h2;
   localparam logic [1:0] ABS_IGNORE_OVF = 2'h2;
   localparam logic [7:0] FC_EEP_PARAM = 8'd36;
   localparam logic [7:0] FC_EEP_CHECK = 8'd37;
   localparam logic [7:0] FC_OVERTRAVEL = 8'd38;
   localparam logic [7:0] FC_AIN_OVER = 8'd39;
   localparam logic [7:0] FC_ABS_DOWN = 8'd40;
   localparam logic [7:0] FC_ABS_OVF = 8'd41;
   localparam logic [7:0] FC_ABS_OVSPD = 8'd42;
   localparam logic [7:0] FC_ENC_INIT = 8'd43;
   localparam logic [7:0] FC_SINGLE_CNT = 8'd44;
   localparam logic [7:0] FC_MULTI_CNT = 8'd45;
   localparam logic [7:0] FC_START_SPD = 8'd47;
   localparam logic [7:0] FC_INDEX_MISS = 8'd48;
   localparam logic [3:0] SUB_0 = 4'h0;
   localparam logic [3:0] SUB_1 = 4'h1;
   localparam logic [3:0] SUB_2 = 4'h2;
endpackage

// ===== sfa_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels on raw
`timescale 1ns/1ps
module sfa_sync3 #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   sfa_sync_if.sync port
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] clean_q;

   initial begin
      if (W < 1) $error("sfa_sync3 width must be positive");
   end

   // ****************************************
   // stages; output follows when 2 and 3 agree
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= port.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         clean_q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) clean_q[i] <= s3_q[i];
         end
      end
   end

   assign port.clean = clean_q;
endmodule

// ===== sfa_sync_if.sv
// carrier between pin synchroniser and fault logic
// assumes both ends on sys_clk
`timescale 1ns/1ps
interface sfa_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// ===== test_servo_fault_alarm_unit.sv
// self-checking bench for the servo fault alarm unit
// assumes sfa_pkg, the design and sfa_enc_model are compiled first
`timescale 1ns/1ps
module test_servo_fault_alarm_unit;
   // ****************************************
   // stimulus and wiring
   // ****************************************
   logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, err, faultActive, irq, encResetDone;
   logic posLim = 0, negLim = 0, aclr = 0, eepDone = 0, eepP = 0, eepC = 0, rstReq = 0;
   logic [1:0] eepSub = 2'h0;
   logic [15:0] ain1 = 16'h0, ain2 = 16'h0, ain3 = 16'h0;
   logic [7:0] flagReq = 8'h00, encFlags, faultMain;
   logic [3:0] faultSub;
   int error_cnt = 0, check_count = 0, tmo = 0;
   logic [7:0] codes [8] = '{8'd40, 8'd41, 8'd42, 8'd43, 8'd44, 8'd45, 8'd47, 8'd48};
   always #2.5 sys_clk = ~sys_clk;
   sfa_enc_model i_sfa_enc_model (.sys_clk(sys_clk), .flagReq(flagReq), .resetReq(rstReq),
      .encFlags(encFlags), .encResetDone(encResetDone));
   sfa_fault_unit i_sfa_fault_unit (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pos_limit_in(posLim), .neg_limit_in(negLim), .alarm_clear_in(aclr), .eepDone(eepDone),
      .eepParamBad(eepP), .eepCheckBad(eepC), .eepSub(eepSub), .ain1Val(ain1), .ain2Val(ain2),
      .ain3Val(ain3), .encBackupLow(encFlags[0]), .encMultiOver(encFlags[1]), .encBattOverspeed(encFlags[2]),
      .encInitFail(encFlags[3]), .encSingleErr(encFlags[4]), .encMultiErr(encFlags[5]),
      .encStartOverspeed(encFlags[6]), .encIndexMissing(encFlags[7]), .encResetDone(encResetDone),
      .faultActive(faultActive), .faultMain(faultMain), .faultSub(faultSub), .irq(irq));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   function automatic logic [31:0] st(input logic [7:0] m, input logic [3:0] s);
      return {15'h0, m != 8'h0, m, 4'h0, s};
   endfunction
   task automatic stat(input logic [7:0] m, input logic [3:0] s);
      apb(0, sfa_pkg::REG_STATUS, 0);
      chk(r, st(m, s));
      chk({faultActive, faultMain, faultSub}, {m != 8'h0, m, s});
   endtask
   task automatic pwr_cycle;
      sys_rst <= 1;
      cyc(10);
      sys_rst <= 0;
      cyc(1);
   endtask
   task automatic clear_pin;
      aclr <= 1;
      cyc(8);
      aclr <= 0;
      cyc(8);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      apb(0, sfa_pkg::REG_CTRL, 0);
      chk(r, 32'h1);
      stat(0, 0);
      apb(0, 8'h40, 0);
      chk({err, r}, {1'b1, 32'h0});
      $display("registers done");
   endtask
   task automatic t_eep;
      for (int k = 0; k < 2; k++) begin
         pwr_cycle();
         eepDone <= 1;
         eepP <= (k == 0);
         eepC <= (k == 1);
         eepSub <= 2'(2 - k);
         cyc(1);
         eepDone <= 0;
         eepP <= 0;
         eepC <= 0;
         cyc(3);
         stat(k == 0 ? sfa_pkg::FC_EEP_PARAM : sfa_pkg::FC_EEP_CHECK, 4'(2 - k));
         clear_pin();
         stat(k == 0 ? 8'd36 : 8'd37, 4'(2 - k));
      end
      $display("eeprom done");
   endtask
   task automatic t_travel;
      pwr_cycle();
      posLim <= 1;
      negLim <= 1;
      cyc(8);
      stat(0, 0);
      posLim <= 0;
      negLim <= 0;
      apb(1, sfa_pkg::REG_CTRL, 32'h0);
      posLim <= 1;
      cyc(8);
      stat(0, 0);
      negLim <= 1;
      cyc(8);
      stat(sfa_pkg::FC_OVERTRAVEL, 0);
      posLim <= 0;
      negLim <= 0;
      clear_pin();
      stat(38, 0);
      pwr_cycle();
      apb(1, sfa_pkg::REG_CTRL, 32'h2);
      negLim <= 1;
      cyc(8);
      stat(38, 0);
      negLim <= 0;
      $display("overtravel done");
   endtask
   task automatic t_ain;
      pwr_cycle();
      apb(1, sfa_pkg::REG_IRQ_MASK, 32'h3);
      ain1 <= 16'hffff;
      apb(1, sfa_pkg::REG_AIN2, 32'h64);
      cyc(4);
      stat(0, 0);
      chk(irq, 0);
      ain2 <= 16'h64;
      cyc(4);
      stat(0, 0);
      ain2 <= 16'h65;
      cyc(4);
      stat(sfa_pkg::FC_AIN_OVER, sfa_pkg::SUB_1);
      chk(irq, 1);
      apb(1, sfa_pkg::REG_IRQ_STAT, 32'h1);
      cyc(1);
      chk(irq, 0);
      clear_pin();
      stat(39, 1);
      ain2 <= 16'h0;
      clear_pin();
      stat(0, 0);
      apb(0, sfa_pkg::REG_IRQ_STAT, 0);
      chk(r, 32'h2);
      chk(irq, 1);
      apb(1, sfa_pkg::REG_IRQ_STAT, 32'h2);
      cyc(1);
      chk(irq, 0);
      apb(1, sfa_pkg::REG_AIN3, 32'h10);
      ain3 <= 16'h11;
      cyc(4);
      stat(sfa_pkg::FC_AIN_OVER, sfa_pkg::SUB_2);
      ain3 <= 16'h0;
      clear_pin();
      stat(0, 0);
      apb(1, sfa_pkg::REG_AIN1, 32'h10);
      cyc(4);
      stat(sfa_pkg::FC_AIN_OVER, sfa_pkg::SUB_0);
      ain1 <= 16'h0;
      clear_pin();
      stat(0, 0);
      $display("analog done");
   endtask
   task automatic t_enc;
      for (int i = 0; i < 8; i++) begin
         pwr_cycle();
         flagReq <= 8'h1 << i;
         cyc(4);
         stat(codes[i], 0);
         flagReq <= 8'h0;
         clear_pin();
         stat(codes[i], 0);
         rstReq <= 1;
         cyc(1);
         rstReq <= 0;
         cyc(4);
         stat((i == 0 || i == 2) ? 8'h0 : codes[i], 0);
      end
      pwr_cycle();
      apb(1, sfa_pkg::REG_CTRL, 32'h21);
      flagReq <= 8'h2;
      cyc(4);
      stat(0, 0);
      flagReq <= 8'h0;
      $display("encoder done");
   endtask
   // ****************************************
   // verdict, timeout and main sequence
   // ****************************************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      tmo++;
      if (tmo == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      cyc(10);
      sys_rst <= 0;
      cyc(1);
      t_regs();
      t_eep();
      t_travel();
      t_ain();
      t_enc();
      end_sim();
   end
endmodule
